// >>> rtl/tsr_pkg.sv
package tsr_pkg;

	// Register select codes (low pointer bits)
	localparam int        PTR_W       = 4;
	localparam logic [3:0] PTR_CAP    = 4'h0;
	localparam logic [3:0] PTR_SETUP  = 4'h1;
	localparam logic [3:0] PTR_UPPER  = 4'h2;
	localparam logic [3:0] PTR_LOWER  = 4'h3;
	localparam logic [3:0] PTR_CRIT   = 4'h4;
	localparam logic [3:0] PTR_AMB    = 4'h5;
	localparam logic [3:0] PTR_MAKER  = 4'h6;
	localparam logic [3:0] PTR_PART   = 4'h7;
	localparam logic [3:0] PTR_RES    = 4'h8;

	// Fixed contents
	localparam logic [15:0] CAP_VALUE  = 16'h00EF;
	localparam logic [15:0] LIMIT_MASK = 16'h1FFC;
	localparam logic [15:0] ZERO16     = 16'h0000;
	localparam logic [7:0]  PTR_RST    = 8'h00;

	// Setup word field positions
	localparam int CFG_HYST_LO = 9;
	localparam int CFG_HALT    = 8;
	localparam int CFG_CLOCK   = 7;
	localparam int CFG_WLOCK   = 6;
	localparam int CFG_ICLR    = 5;
	localparam int CFG_STAT    = 4;
	localparam int CFG_EN      = 3;
	localparam int CFG_SEL     = 2;
	localparam int CFG_POL     = 1;
	localparam int CFG_MODE    = 0;

	// Ambient word flag positions
	localparam int TA_CRIT_BIT = 15;
	localparam int TA_HI_BIT   = 14;
	localparam int TA_LO_BIT   = 13;

	// Reset values
	localparam logic [1:0]  HYST_RST  = 2'h0;
	localparam logic [1:0]  RES_RST   = 2'h1;
	localparam logic [12:0] TEMP_RST  = 13'h0000;

	// Hysteresis in 1/16 degree steps: 0, 1.5, 3.0, 6.0
	localparam logic signed [13:0] HYST_0 = 14'sh0000;
	localparam logic signed [13:0] HYST_1 = 14'sh0018;
	localparam logic signed [13:0] HYST_2 = 14'sh0030;
	localparam logic signed [13:0] HYST_3 = 14'sh0060;

	// Conversion timing
	localparam int CLK_FREQ_HZ    = 40_000_000;
	localparam int CONV_PERIOD_US = 125_000;
	localparam int CONV_CYCLES    = (CLK_FREQ_HZ / 1_000_000) * CONV_PERIOD_US;

	// Identity codes, values arbitrary
	localparam logic [15:0] MAKER_CODE = 16'hA5C3;
	localparam logic [15:0] PART_CODE  = 16'h7E02;

	typedef struct packed {
		logic        ptr_wr;
		logic        wr;
		logic        rd;
		logic [15:0] data;
	} tsr_req_t;

	typedef struct packed {
		logic        busy;
		logic        rd_valid;
		logic [15:0] rd_data;
	} tsr_rsp_t;

endpackage

// >>> rtl/tsr_sync2.sv
`timescale 1ns/1ps
module tsr_sync2 (
	// Destination clock
	input  wire logic clk,
	input  wire logic rst,
	// Level in, level out
	input  wire logic d,
	output logic      q
);

	logic meta_r;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			meta_r <= 1'b0;
			q      <= 1'b0;
		end else begin
			meta_r <= d;
			q      <= meta_r;
		end
	end

endmodule

// >>> rtl/tsr_link_port.sv
`timescale 1ns/1ps
module tsr_link_port (
	// Clocks and reset
	input  wire logic             link_clk,
	input  wire logic             sys_clk,
	input  wire logic             rst,
	// Link side
	input  wire tsr_pkg::tsr_req_t lnk_req,
	output tsr_pkg::tsr_rsp_t     lnk_rsp,
	// System side
	output tsr_pkg::tsr_req_t     sys_cmd,
	output logic                  sys_stb,
	input  wire logic [15:0]      sys_rd_data
);

	tsr_pkg::tsr_req_t hold_r;
	logic              req_tgl_r;
	logic              ack_s;
	logic              ack_d_r;
	logic              req_s;
	logic              req_d_r;
	logic              ack_tgl_r;
	logic              take;
	logic              done;

	assign take = !lnk_rsp.busy && (lnk_req.ptr_wr || lnk_req.wr || lnk_req.rd);
	assign done = ack_s ^ ack_d_r;

	// Held request is stable while busy, so the toggle alone crosses
	always_ff @(posedge link_clk or posedge rst) begin
		if (rst) begin
			hold_r    <= '0;
			req_tgl_r <= 1'b0;
			ack_d_r   <= 1'b0;
			lnk_rsp   <= '0;
		end else begin
			ack_d_r           <= ack_s;
			lnk_rsp.rd_valid  <= done && hold_r.rd;
			if (take) begin
				hold_r       <= lnk_req;
				req_tgl_r    <= !req_tgl_r;
				lnk_rsp.busy <= 1'b1;
			end else if (done) begin
				lnk_rsp.busy <= 1'b0;
			end
			if (done && hold_r.rd) begin
				lnk_rsp.rd_data <= sys_rd_data;
			end
		end
	end

	tsr_sync2 u_req_sync (
		.clk (sys_clk),
		.rst (rst),
		.d   (req_tgl_r),
		.q   (req_s)
	);

	tsr_sync2 u_ack_sync (
		.clk (link_clk),
		.rst (rst),
		.d   (ack_tgl_r),
		.q   (ack_s)
	);

	// Ack goes one cycle after the strobe, once read data are registered
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			req_d_r   <= 1'b0;
			sys_stb   <= 1'b0;
			sys_cmd   <= '0;
			ack_tgl_r <= 1'b0;
		end else begin
			req_d_r   <= req_s;
			sys_stb   <= req_s ^ req_d_r;
			ack_tgl_r <= ack_tgl_r ^ sys_stb;
			if (req_s ^ req_d_r) begin
				sys_cmd <= hold_r;
			end
		end
	end

endmodule

// >>> rtl/tsr_regs.sv
`timescale 1ns/1ps
// Behaviour
// - 8-bit pointer, low four bits select
// - Codes 0-8 select the nine registers
// - Codes 1xxx above resolution are reserved
// - Ambient read-only, loaded whole each period
// - Upper/lower limits RW, window drives event
// - Critical limit compared in addition
// - Limits keep only bits 12-2
// - Ambient flags 15-13, sign, 12-bit value
// - Capability fixed, upper byte zero
// - Capability reports quarter degree, range, grade
// - Fixed maker and part/revision codes
// - Setup word field layout
// - Resolution byte at code 8, reset 1
// - Halt stops conversion, holds result, drops event
// - Locks block limit writes until reset
// - Interrupt clear drops latch, reads zero
// - Hysteresis 0/1.5/3/6 degrees on window
module tsr_regs #(
	parameter int CONV_CYCLES = tsr_pkg::CONV_CYCLES
) (
	// Clocks and reset
	input  wire logic              sys_clk,
	input  wire logic              sys_rst,
	input  wire logic              link_clk,
	// Register link
	input  wire tsr_pkg::tsr_req_t lnk_req,
	output tsr_pkg::tsr_rsp_t      lnk_rsp,
	// Converter result
	input  wire logic [12:0]       adc_result,
	// Event pin
	output logic                   event_pin_r
);

	tsr_pkg::tsr_req_t cmd;
	logic              stb;
	logic [15:0]       rd_data_r;
	logic [7:0]        ptr_r;
	logic [3:0]        sel;
	logic [1:0]        hyst_r;
	logic              halt_r;
	logic              crit_lock_r;
	logic              win_lock_r;
	logic              evt_en_r;
	logic              evt_sel_r;
	logic              evt_pol_r;
	logic              evt_mode_r;
	logic              evt_stat_r;
	logic [15:0]       upper_r;
	logic [15:0]       lower_r;
	logic [15:0]       crit_r;
	logic [1:0]        res_r;
	logic [15:0]       ta_r;
	logic [31:0]       conv_cnt_r;
	logic              conv_end;
	logic              wr_setup;
	logic              any_lock;
	logic              icl;
	logic              cond;
	logic              cond_d_r;
	logic              irq_r;
	logic              asserted;
	logic signed [13:0] amb;
	logic signed [13:0] hyst;
	logic              hi_nxt;
	logic              lo_nxt;
	logic              crit_nxt;

	function automatic logic signed [13:0] lim_q4(input logic [15:0] v);
		return {v[12], v[12:2], 2'b00};
	endfunction

	function automatic logic [15:0] read_word(input logic [3:0] code);
		logic [15:0] w;
		w = tsr_pkg::ZERO16;
		unique case (code)
			tsr_pkg::PTR_CAP:   w = tsr_pkg::CAP_VALUE;
			tsr_pkg::PTR_SETUP: begin
				w[tsr_pkg::CFG_HYST_LO +: 2] = hyst_r;
				w[tsr_pkg::CFG_HALT]         = halt_r;
				w[tsr_pkg::CFG_CLOCK]        = crit_lock_r;
				w[tsr_pkg::CFG_WLOCK]        = win_lock_r;
				w[tsr_pkg::CFG_STAT]         = evt_stat_r;
				w[tsr_pkg::CFG_EN]           = evt_en_r;
				w[tsr_pkg::CFG_SEL]          = evt_sel_r;
				w[tsr_pkg::CFG_POL]          = evt_pol_r;
				w[tsr_pkg::CFG_MODE]         = evt_mode_r;
			end
			tsr_pkg::PTR_UPPER: w = upper_r;
			tsr_pkg::PTR_LOWER: w = lower_r;
			tsr_pkg::PTR_CRIT:  w = crit_r;
			tsr_pkg::PTR_AMB:   w = ta_r;
			tsr_pkg::PTR_MAKER: w = tsr_pkg::MAKER_CODE;
			tsr_pkg::PTR_PART:  w = tsr_pkg::PART_CODE;
			tsr_pkg::PTR_RES:   w = {14'h0000, res_r};
			default:            w = tsr_pkg::ZERO16;
		endcase
		return w;
	endfunction

	tsr_link_port u_link (
		.link_clk    (link_clk),
		.sys_clk     (sys_clk),
		.rst         (sys_rst),
		.lnk_req     (lnk_req),
		.lnk_rsp     (lnk_rsp),
		.sys_cmd     (cmd),
		.sys_stb     (stb),
		.sys_rd_data (rd_data_r)
	);

	assign sel      = ptr_r[tsr_pkg::PTR_W-1:0];
	assign wr_setup = stb && cmd.wr && sel == tsr_pkg::PTR_SETUP;
	assign any_lock = crit_lock_r || win_lock_r;
	assign icl      = wr_setup && cmd.data[tsr_pkg::CFG_ICLR];

	// Upper bits kept as written; host keeps them zero
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			ptr_r <= tsr_pkg::PTR_RST;
		end else if (stb && cmd.ptr_wr) begin
			ptr_r <= cmd.data[7:0];
		end
	end

	// Reads sample the selected word; reserved codes read zero
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			rd_data_r <= tsr_pkg::ZERO16;
		end else if (stb && cmd.rd) begin
			rd_data_r <= read_word(sel);
		end
	end

	// Setup word; locks are sticky until reset
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			hyst_r      <= tsr_pkg::HYST_RST;
			halt_r      <= 1'b0;
			crit_lock_r <= 1'b0;
			win_lock_r  <= 1'b0;
			evt_en_r    <= 1'b0;
			evt_sel_r   <= 1'b0;
			evt_pol_r   <= 1'b0;
			evt_mode_r  <= 1'b0;
		end else if (wr_setup) begin
			crit_lock_r <= crit_lock_r || cmd.data[tsr_pkg::CFG_CLOCK];
			win_lock_r  <= win_lock_r || cmd.data[tsr_pkg::CFG_WLOCK];
			if (!any_lock) begin
				hyst_r     <= cmd.data[tsr_pkg::CFG_HYST_LO +: 2];
				halt_r     <= cmd.data[tsr_pkg::CFG_HALT];
				evt_en_r   <= cmd.data[tsr_pkg::CFG_EN];
				evt_pol_r  <= cmd.data[tsr_pkg::CFG_POL];
				evt_mode_r <= cmd.data[tsr_pkg::CFG_MODE];
			end else if (!cmd.data[tsr_pkg::CFG_HALT]) begin
				// Halt may still be left while locked
				halt_r <= 1'b0;
			end
			if (!win_lock_r) begin
				evt_sel_r <= cmd.data[tsr_pkg::CFG_SEL];
			end
		end
	end

	// Limit words drop unimplemented bits
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			upper_r <= tsr_pkg::ZERO16;
			lower_r <= tsr_pkg::ZERO16;
			crit_r  <= tsr_pkg::ZERO16;
			res_r   <= tsr_pkg::RES_RST;
		end else if (stb && cmd.wr) begin
			unique case (sel)
				tsr_pkg::PTR_UPPER: if (!win_lock_r) upper_r <= cmd.data & tsr_pkg::LIMIT_MASK;
				tsr_pkg::PTR_LOWER: if (!win_lock_r) lower_r <= cmd.data & tsr_pkg::LIMIT_MASK;
				tsr_pkg::PTR_CRIT:  if (!crit_lock_r) crit_r <= cmd.data & tsr_pkg::LIMIT_MASK;
				tsr_pkg::PTR_RES:   res_r <= cmd.data[1:0];
				default:            ;
			endcase
		end
	end

	// Conversion period timer, frozen during halt
	assign conv_end = !halt_r && conv_cnt_r == 32'(CONV_CYCLES - 1);

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			conv_cnt_r <= 32'h00000000;
		end else if (halt_r) begin
			conv_cnt_r <= conv_cnt_r;
		end else if (conv_end) begin
			conv_cnt_r <= 32'h00000000;
		end else begin
			conv_cnt_r <= conv_cnt_r + 32'h00000001;
		end
	end

	// Window flags with hysteresis toward the inside
	always_comb begin
		amb = {adc_result[12], adc_result};
		unique case (hyst_r)
			2'h0: hyst = tsr_pkg::HYST_0;
			2'h1: hyst = tsr_pkg::HYST_1;
			2'h2: hyst = tsr_pkg::HYST_2;
			2'h3: hyst = tsr_pkg::HYST_3;
		endcase
		crit_nxt = amb >= lim_q4(crit_r);
		if (ta_r[tsr_pkg::TA_HI_BIT]) begin
			hi_nxt = amb > lim_q4(upper_r) - hyst;
		end else begin
			hi_nxt = amb > lim_q4(upper_r);
		end
		if (ta_r[tsr_pkg::TA_LO_BIT]) begin
			lo_nxt = amb < lim_q4(lower_r) + hyst;
		end else begin
			lo_nxt = amb < lim_q4(lower_r);
		end
	end

	// Whole word loads at once so flags never mix with stale data
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			ta_r <= {3'h0, tsr_pkg::TEMP_RST};
		end else if (conv_end) begin
			ta_r <= {crit_nxt, hi_nxt, lo_nxt, adc_result};
		end
	end

	assign cond = ta_r[tsr_pkg::TA_CRIT_BIT] ||
		(!evt_sel_r && (ta_r[tsr_pkg::TA_HI_BIT] || ta_r[tsr_pkg::TA_LO_BIT]));

	// Latched flag: a new event in the clear cycle still sets it
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			cond_d_r <= 1'b0;
			irq_r    <= 1'b0;
		end else begin
			cond_d_r <= cond;
			if (cond && !cond_d_r) begin
				irq_r <= 1'b1;
			end else if (icl) begin
				irq_r <= 1'b0;
			end
		end
	end

	assign asserted = evt_en_r && !halt_r && (evt_mode_r ? irq_r : cond);

	// Polarity 0 is active low, so the idle pin sits high
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			evt_stat_r  <= 1'b0;
			event_pin_r <= 1'b1;
		end else begin
			evt_stat_r  <= asserted;
			event_pin_r <= evt_pol_r ? asserted : !asserted;
		end
	end

endmodule

// >>> sim/tsr_regs_monitor.sv
`timescale 1ns/1ps
module tsr_regs_monitor #(
	parameter int CONV_CYCLES = 40
) (
	// Clocks and reset
	input wire logic              sys_clk,
	input wire logic              sys_rst,
	input wire logic              link_clk,
	// Register link
	input wire tsr_pkg::tsr_req_t lnk_req,
	input wire tsr_pkg::tsr_rsp_t lnk_rsp,
	// Converter and pin
	input wire logic [12:0]       adc_result,
	input wire logic              event_pin_r
);
	wire  bsy  = lnk_rsp.busy;
	wire  rdv  = lnk_rsp.rd_valid;
	wire  take = !bsy && (lnk_req.ptr_wr || lnk_req.wr || lnk_req.rd);
	logic rd_kind_r;

	// Kind in flight, so a write can never be answered as a read
	always_ff @(posedge link_clk or posedge sys_rst) begin
		if (sys_rst)
			rd_kind_r <= 1'h0;
		else if (take)
			rd_kind_r <= lnk_req.rd;
	end

	property p_take_busy; @(posedge link_clk) disable iff (sys_rst) take |-> ##[1:2] bsy; endproperty
	a_take_busy: assert property (p_take_busy) else $error("busy missing");
	property p_busy_cause; @(posedge link_clk) disable iff (sys_rst) $rose(bsy) |-> $past(take) || $past(take, 2); endproperty
	a_busy_cause: assert property (p_busy_cause) else $error("busy without request");
	property p_busy_min; @(posedge link_clk) disable iff (sys_rst) $rose(bsy) |-> bsy[*2]; endproperty
	a_busy_min: assert property (p_busy_min) else $error("answer too early");
	property p_busy_max; @(posedge link_clk) disable iff (sys_rst) $rose(bsy) |-> ##[1:30] !bsy; endproperty
	a_busy_max: assert property (p_busy_max) else $error("answer too late");
	property p_rdv_kind; @(posedge link_clk) disable iff (sys_rst) $fell(bsy) |-> rdv == rd_kind_r; endproperty
	a_rdv_kind: assert property (p_rdv_kind) else $error("answer kind wrong");
	property p_rdv_when; @(posedge link_clk) disable iff (sys_rst) rdv |-> $fell(bsy); endproperty
	a_rdv_when: assert property (p_rdv_when) else $error("stray read answer");
	property p_rd_hold; @(posedge link_clk) disable iff (sys_rst) $changed(lnk_rsp.rd_data) |-> rdv; endproperty
	a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
	property p_evt_rst; @(posedge sys_clk) disable iff (sys_rst) $fell(sys_rst) |-> event_pin_r[*2]; endproperty
	a_evt_rst: assert property (p_evt_rst) else $error("event pin active at start");
endmodule

// >>> sim/tsr_host_model.sv
`timescale 1ns/1ps
module tsr_host_model (
	// Link clock
	input  wire logic              link_clk,
	// Request out, answer in
	output tsr_pkg::tsr_req_t      lnk_req,
	input  wire tsr_pkg::tsr_rsp_t lnk_rsp
);
	initial lnk_req = '0;

	// Kind 0 pointer, 1 write, 2 read; idle gives a slow host
	task automatic xfer(input logic [1:0] k, input logic [15:0] d, input int idle,
		output logic [15:0] q, output logic ok);
		int n;
		repeat (idle) @(negedge link_clk);
		// Pointer byte bits 7-4 clear; callers use codes 0-8 only
		lnk_req = '{ptr_wr: k == 2'h0, wr: k == 2'h1, rd: k == 2'h2, data: (k == 2'h0) ? {12'h000, d[3:0]} : d};
		@(posedge link_clk);
		@(negedge link_clk);
		// Released data shows the inverse, never a stale copy
		lnk_req = '{ptr_wr: 1'h0, wr: 1'h0, rd: 1'h0, data: ~d};
		n = 0;
		@(negedge link_clk);
		while (lnk_rsp.busy !== 1'h0 && n < 40) begin
			@(negedge link_clk);
			n++;
		end
		ok = (n < 40) && (lnk_rsp.rd_valid === (k == 2'h2));
		q = lnk_rsp.rd_data;
	endtask
endmodule

// >>> sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	localparam int CONV = 40;
	logic              sys_clk     = 1'h0;
	logic              link_clk    = 1'h0;
	logic              sys_rst     = 1'h1;
	logic [12:0]       adc_result  = 13'h0000;
	logic              event_pin_r;
	tsr_pkg::tsr_req_t lnk_req;
	tsr_pkg::tsr_rsp_t lnk_rsp;
	logic [15:0]       q;
	logic              ok;
	int                gap         = 0;
	int                err_total   = 0;
	int                check_count = 0;
	logic [15:0]       rv [9]      = '{{8'h00, tsr_pkg::CAP_VALUE[7:5], 5'h0F}, 16'h0000, 16'h0000, 16'h0000,
		16'h0000, 16'h0000, tsr_pkg::MAKER_CODE, tsr_pkg::PART_CODE, 16'h0001};
	// At crit, at upper, at lower, inside, below zero
	logic [12:0]       tv [5]      = '{13'h01E0, 13'h0190, 13'h0140, 13'h0160, 13'h1F00};
	logic [15:0]       te [5]      = '{16'hC1E0, 16'h0190, 16'h0140, 16'h0160, 16'h3F00};

	always #12.5 sys_clk = ~sys_clk;
	// Odd offset keeps the two clocks out of step
	always begin
		#1.3;
		forever #3 link_clk = ~link_clk;
	end

	tsr_regs #(.CONV_CYCLES(CONV)) uut (.sys_clk(sys_clk), .sys_rst(sys_rst), .link_clk(link_clk),
		.lnk_req(lnk_req), .lnk_rsp(lnk_rsp), .adc_result(adc_result), .event_pin_r(event_pin_r));
	tsr_host_model host (.link_clk(link_clk), .lnk_req(lnk_req), .lnk_rsp(lnk_rsp));

	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		check_count++;
		if (g !== e) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic io(input logic [1:0] k, input logic [15:0] d);
		host.xfer(k, d, gap, q, ok);
		chk("handshake", 16'h0001, {15'h0000, ok});
	endtask

	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		io(2'h0, {12'h000, a});
		io(2'h1, d);
	endtask

	task automatic rd(input logic [3:0] a, input logic [15:0] e);
		io(2'h0, {12'h000, a});
		io(2'h2, 16'h0000);
		chk($sformatf("register %0h", a), e, q);
	endtask

	task automatic scan();
		for (int i = 0; i < 9; i++)
			if (i != 5)
				rd(4'(i), rv[i]);
	endtask

	// Two periods, so at least one load lands whatever the phase
	task automatic amb(input logic [12:0] t, input logic [15:0] e);
		@(negedge sys_clk);
		adc_result = t;
		repeat (2 * CONV) @(negedge sys_clk);
		@(negedge link_clk);
		rd(tsr_pkg::PTR_AMB, e);
	endtask

	task automatic evt(input logic e);
		repeat (10) @(negedge link_clk);
		chk("event pin", {15'h0000, e}, {15'h0000, event_pin_r});
	endtask

	task automatic print_verdict();
		if (err_total == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	initial begin
		#200000;
		err_total++;
		print_verdict();
	end

	initial begin
		repeat (16) @(posedge sys_clk);
		@(negedge sys_clk);
		sys_rst = 1'h0;
		repeat (20) @(negedge link_clk);
		rd(tsr_pkg::PTR_AMB, 16'h0000);
		scan();
		for (int i = 5; i < 9; i++)
			wr(4'(i % 8), 16'hFFFF);
		gap = 3;
		scan();
		gap = 0;
		wr(tsr_pkg::PTR_UPPER, 16'hFFFF);
		rd(tsr_pkg::PTR_UPPER, 16'h1FFC);
		wr(tsr_pkg::PTR_UPPER, 16'h0190);
		wr(tsr_pkg::PTR_LOWER, 16'h0140);
		wr(tsr_pkg::PTR_CRIT, 16'h01E0);
		for (int i = 0; i < 5; i++)
			amb(tv[i], te[i]);
		wr(tsr_pkg::PTR_SETUP, 16'hF808);
		evt(1'h0);
		rd(tsr_pkg::PTR_SETUP, 16'h0018);
		wr(tsr_pkg::PTR_SETUP, 16'h0128);
		evt(1'h1);
		rd(tsr_pkg::PTR_SETUP, 16'h0108);
		amb(13'h0160, 16'h3F00);
		wr(tsr_pkg::PTR_SETUP, 16'h0008);
		amb(13'h0160, 16'h0160);
		evt(1'h1);
		// Hysteresis code 1 holds each flag 1.5 degrees inside the window
		wr(tsr_pkg::PTR_SETUP, 16'h0208);
		amb(13'h01A0, 16'h41A0);
		amb(13'h0180, 16'h4180);
		evt(1'h0);
		amb(13'h0170, 16'h0170);
		amb(13'h0130, 16'h2130);
		amb(13'h0150, 16'h2150);
		amb(13'h0160, 16'h0160);
		evt(1'h1);
		// Interrupt mode, active high: the latch outlives the condition
		wr(tsr_pkg::PTR_SETUP, 16'h002B);
		evt(1'h0);
		rd(tsr_pkg::PTR_SETUP, 16'h000B);
		amb(13'h01A0, 16'h41A0);
		evt(1'h1);
		amb(13'h0160, 16'h0160);
		evt(1'h1);
		wr(tsr_pkg::PTR_SETUP, 16'h002B);
		evt(1'h0);
		// Critical only: the window no longer drives the pin
		wr(tsr_pkg::PTR_SETUP, 16'h000E);
		amb(13'h01A0, 16'h41A0);
		evt(1'h0);
		amb(13'h01E0, 16'hC1E0);
		evt(1'h1);
		wr(tsr_pkg::PTR_SETUP, 16'h0080);
		wr(tsr_pkg::PTR_CRIT, 16'h0000);
		rd(tsr_pkg::PTR_CRIT, 16'h01E0);
		wr(tsr_pkg::PTR_SETUP, 16'h0040);
		wr(tsr_pkg::PTR_UPPER, 16'h0000);
		rd(tsr_pkg::PTR_UPPER, 16'h0190);
		rd(tsr_pkg::PTR_SETUP, 16'h00C0);
		print_verdict();
	end
endmodule

bind tsr_regs tsr_regs_monitor #(.CONV_CYCLES(CONV_CYCLES)) mon (.sys_clk(sys_clk), .sys_rst(sys_rst),
	.link_clk(link_clk), .lnk_req(lnk_req), .lnk_rsp(lnk_rsp), .adc_result(adc_result), .event_pin_r(event_pin_r));
